// File: inc/dma_event_defs.vh
// Purpose: constants for the hash dma event status block
// Assumes: 32-bit axi4-lite register bus
// Notes: byte offsets, field positions, reset values
`ifndef DMA_EVENT_DEFS_VH
`define DMA_EVENT_DEFS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_MASK 12'h810
`define OFS_RAW 12'h814
`define OFS_MASKED 12'h818
`define OFS_ACK 12'h81C
`define OFS_IRQ_EN 12'h820
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define EV_W 3
`define EV_DIN 2
`define EV_COUT 1
`define EV_CIN 0
`define MASK_RST 3'h7
`define EV_ZERO 3'h0
`define IRQ_EN_RST 1'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define WORD_ZERO 32'h00000000
`define ADDR_LSB 2
`endif

// File: design/dma_event_status.v
// Purpose: raw, masked and acknowledge status for the hash dma events
// Assumes: one clock, event pulses synchronous to CLK_SYS
// Notes: registers reached over axi4-lite, one word each
`include "dma_event_defs.vh"

// Notes on behaviour
// - raw bit 2 sets when dma finishes input data; resets to zero.
// - raw bit 1 sets when dma finishes context output; resets to zero.
// - raw bit 0 sets when dma finishes context input; resets to zero.
// - raw status is read-only; upper bits reserved; writes to it never alter flags.
// - masked status bits show raw flags gated by their mask bits.
// - writing one to an acknowledge bit clears that event flag.
// - acknowledge register always reads zero.
// - three read-write mask bits, reset to one, enable event interrupts.
module dma_event_status #(
   parameter AW = 12
)(
   input wire CLK_SYS,
   input wire NRST,
   input wire EV_DIN_DONE,
   input wire EV_COUT_DONE,
   input wire EV_CIN_DONE,
   input wire [AW-1:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output reg S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output reg S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [AW-1:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output reg S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY,
   output reg IRQ
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg [`EV_W-1:0] raw_q;
   reg [`EV_W-1:0] raw_d;
   reg [`EV_W-1:0] mask_q;
   reg irq_en_q;
   reg [AW-1:0] awaddr_q;
   reg aw_have_q;
   reg [31:0] wdata_q;
   reg w_have_q;
   wire [`EV_W-1:0] events;
   wire wr_fire;
   wire [AW-1:0] wa;
   wire [31:0] wd;
   wire [`EV_W-1:0] ack_bits;
   wire [`EV_W-1:0] masked;

   // word-aligned compare, low address bits ignored
   function hit;
      input [AW-1:0] a;
      input [11:0] ofs;
      begin
         hit = (a[AW-1:`ADDR_LSB] == ofs[AW-1:`ADDR_LSB]);
      end
   endfunction

   assign events = {EV_DIN_DONE, EV_COUT_DONE, EV_CIN_DONE};
   assign masked = raw_q & mask_q;
   assign wa = aw_have_q ? awaddr_q : S_AXI_AWADDR;
   assign wd = w_have_q ? wdata_q : S_AXI_WDATA;
   // take the write once both halves are present and no response waits
   assign wr_fire = (aw_have_q | S_AXI_AWVALID) & (w_have_q | S_AXI_WVALID) & ~S_AXI_BVALID;
   assign ack_bits = (wr_fire && hit(wa, `OFS_ACK) && S_AXI_WSTRB[0]) ?
                     wd[`EV_W-1:0] : `EV_ZERO;

   // ----------------------------------------
   // event flags
   // ----------------------------------------
   // set beats clear so a pulse in the ack cycle is not lost
   always @*
   begin
      raw_d = (raw_q & ~ack_bits) | events;
   end

   always @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         raw_q <= `EV_ZERO;
         mask_q <= `MASK_RST;
         irq_en_q <= `IRQ_EN_RST;
         IRQ <= 1'b0;
      end
      else
      begin
         raw_q <= raw_d;
         if (wr_fire && hit(wa, `OFS_MASK) && S_AXI_WSTRB[0])
         begin
            mask_q <= wd[`EV_W-1:0];
         end
         if (wr_fire && hit(wa, `OFS_IRQ_EN) && S_AXI_WSTRB[0])
         begin
            irq_en_q <= wd[0];
         end
         // updates at the same edge as the flags, from a flop
         IRQ <= irq_en_q & (|(raw_d & mask_q));
      end
   end

   // ----------------------------------------
   // write channel
   // ----------------------------------------
   always @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         awaddr_q <= {AW{1'b0}};
         aw_have_q <= 1'b0;
         wdata_q <= `WORD_ZERO;
         w_have_q <= 1'b0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `RESP_OKAY;
      end
      else
      begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         if (wr_fire)
         begin
            S_AXI_AWREADY <= ~aw_have_q;
            S_AXI_WREADY <= ~w_have_q;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            // raw and masked status are read-only; writing them is an error
            if (hit(wa, `OFS_MASK) || hit(wa, `OFS_ACK) || hit(wa, `OFS_IRQ_EN))
            begin
               S_AXI_BRESP <= `RESP_OKAY;
            end
            else
            begin
               S_AXI_BRESP <= `RESP_SLVERR;
            end
         end
         else
         begin
            if (S_AXI_AWVALID && !aw_have_q && !S_AXI_AWREADY)
            begin
               awaddr_q <= S_AXI_AWADDR;
               aw_have_q <= 1'b1;
               S_AXI_AWREADY <= 1'b1;
            end
            if (S_AXI_WVALID && !w_have_q && !S_AXI_WREADY)
            begin
               wdata_q <= S_AXI_WDATA;
               w_have_q <= 1'b1;
               S_AXI_WREADY <= 1'b1;
            end
            if (S_AXI_BVALID && S_AXI_BREADY)
            begin
               S_AXI_BVALID <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   always @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= `WORD_ZERO;
         S_AXI_RRESP <= `RESP_OKAY;
      end
      else
      begin
         S_AXI_ARREADY <= 1'b0;
         if (S_AXI_RVALID)
         begin
            if (S_AXI_RREADY)
            begin
               S_AXI_RVALID <= 1'b0;
            end
         end
         else if (S_AXI_ARVALID && !S_AXI_ARREADY)
         begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= `RESP_OKAY;
            S_AXI_RDATA <= `WORD_ZERO;
            if (hit(S_AXI_ARADDR, `OFS_MASK))
            begin
               S_AXI_RDATA[`EV_W-1:0] <= mask_q;
            end
            else if (hit(S_AXI_ARADDR, `OFS_RAW))
            begin
               S_AXI_RDATA[`EV_W-1:0] <= raw_q;
            end
            else if (hit(S_AXI_ARADDR, `OFS_MASKED))
            begin
               S_AXI_RDATA[`EV_W-1:0] <= masked;
            end
            else if (hit(S_AXI_ARADDR, `OFS_ACK))
            begin
               S_AXI_RDATA <= `WORD_ZERO;
            end
            else if (hit(S_AXI_ARADDR, `OFS_IRQ_EN))
            begin
               S_AXI_RDATA[0] <= irq_en_q;
            end
            else
            begin
               S_AXI_RRESP <= `RESP_SLVERR;
            end
         end
      end
   end

endmodule // dma_event_status

// File: bench/dma_event_status_monitor.sv
// Purpose: bus and irq checks
// Assumes: one clock, async low reset
// Notes: bound onto the top ports
module dma_event_status_monitor #(
   parameter AW = 12
)(
   input logic CLK_SYS,
   input logic NRST,
   input logic S_AXI_AWVALID,
   input logic S_AXI_AWREADY,
   input logic S_AXI_WVALID,
   input logic S_AXI_WREADY,
   input logic S_AXI_BVALID,
   input logic S_AXI_BREADY,
   input logic [AW-1:0] S_AXI_ARADDR,
   input logic S_AXI_ARVALID,
   input logic S_AXI_ARREADY,
   input logic [31:0] S_AXI_RDATA,
   input logic S_AXI_RVALID,
   input logic S_AXI_RREADY,
   input logic EV_DIN_DONE,
   input logic EV_COUT_DONE,
   input logic EV_CIN_DONE,
   input logic IRQ
);
   timeunit 1ns;
   timeprecision 1ns;
   wire ev = EV_DIN_DONE | EV_COUT_DONE | EV_CIN_DONE;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   sequence s_rd;
      S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY;
   endsequence
   a_read_answer: assert property (s_rd |=> S_AXI_ARREADY && S_AXI_RVALID)
      else $error("read not answered");
   a_ack_reads_zero: assert property (s_rd ##0 S_AXI_ARADDR == 'h81C |=> S_AXI_RDATA == 0)
      else $error("ack word not zero");
   a_upper_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:3] == 0)
      else $error("reserved bits set");
   a_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");
   a_write_answer: assert property (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID
      && !S_AXI_AWREADY && !S_AXI_WREADY |=> S_AXI_BVALID && S_AXI_WREADY)
      else $error("write not answered");
   a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write response dropped");
   a_irq_rise_cause: assert property ($rose(IRQ) |-> $past(ev) || $past(ev, 2)
      || $past(S_AXI_WREADY) || $past(S_AXI_WREADY, 2))
      else $error("irq rose without cause");
   // an ack clears irq at the take edge, so the ready pulse shows in the same sample
   a_irq_fall_cause: assert property ($fell(IRQ) |-> S_AXI_WREADY || $past(S_AXI_WREADY))
      else $error("irq fell without write");
endmodule // dma_event_status_monitor

// File: bench/dma_event_source.sv
// Purpose: dma side event pulses
// Assumes: start bits held one cycle
// Notes: input data event waits for its last word
module dma_event_source (
   input logic CLK_SYS,
   input logic NRST,
   input logic [2:0] start,
   input logic [3:0] words,
   output logic EV_DIN_DONE,
   output logic EV_COUT_DONE,
   output logic EV_CIN_DONE
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] left_q;
   always @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         left_q <= 4'h0;
         {EV_DIN_DONE, EV_COUT_DONE, EV_CIN_DONE} <= 3'h0;
      end
      else
      begin
         left_q <= start[2] ? words : left_q - (left_q != 4'h0);
         EV_DIN_DONE <= left_q == 4'h1;
         {EV_COUT_DONE, EV_CIN_DONE} <= start[1:0];
      end
   end
endmodule // dma_event_source

// File: bench/test_hash_dma_event_status.sv
// Purpose: self-checking bench
// Assumes: 20 MHz clock
// Notes: ready held back one cycle to stall
`include "dma_event_defs.vh"
module test_hash_dma_event_status;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK_SYS = 1'b0;
   logic NRST = 1'b0;
   logic [2:0] start = 3'h0;
   logic [3:0] words = 4'h3;
   logic [11:0] S_AXI_AWADDR = 12'h0, S_AXI_ARADDR = 12'h0;
   logic [31:0] S_AXI_WDATA = 32'h0;
   logic [3:0] S_AXI_WSTRB = 4'hF;
   logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
   wire EV_DIN_DONE, EV_COUT_DONE, EV_CIN_DONE, IRQ;
   wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
   wire [31:0] S_AXI_RDATA;
   int fail_count = 0, compares = 0;
   always #25 CLK_SYS = ~CLK_SYS;
   dma_event_status u_dut (.*);
   dma_event_source u_src (.*);
   task automatic complete_run;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
      int n;
      @(posedge CLK_SYS);
      n = 0;
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= v;
      {S_AXI_AWVALID, S_AXI_WVALID} <= 2'h3;
      do
      begin
         @(posedge CLK_SYS);
         n++;
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
         S_AXI_BREADY <= S_AXI_BVALID && !S_AXI_BREADY;
      end
      while (!(S_AXI_BVALID && S_AXI_BREADY) && n < 20);
      if (n == 20) fail_count++;
      if (n == 20) complete_run;
      check({30'h0, S_AXI_BRESP}, {30'h0, er});
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      int n;
      @(posedge CLK_SYS);
      n = 0;
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      do
      begin
         @(posedge CLK_SYS);
         n++;
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
         S_AXI_RREADY <= S_AXI_RVALID && !S_AXI_RREADY;
      end
      while (!(S_AXI_RVALID && S_AXI_RREADY) && n < 20);
      if (n == 20) fail_count++;
      if (n == 20) complete_run;
      check(S_AXI_RDATA, exp);
   endtask
   task automatic t_reset;
      rd(`OFS_RAW, 0);
      rd(`OFS_MASK, 7);
      rd(`OFS_ACK, 0);
      check({31'h0, IRQ}, 0);
   endtask
   task automatic t_events;
      @(posedge CLK_SYS);
      start <= 3'h7;
      @(posedge CLK_SYS);
      start <= 3'h0;
      repeat (6) @(posedge CLK_SYS);
      rd(`OFS_RAW, 7);
      rd(`OFS_MASKED, 7);
      check({31'h0, IRQ}, 1);
      wr(`OFS_RAW, 0, `RESP_SLVERR);
      rd(`OFS_RAW, 7);
      rd(`OFS_ACK, 0);
   endtask
   task automatic t_mask_ack;
      wr(`OFS_MASK, 2, `RESP_OKAY);
      rd(`OFS_MASKED, 2);
      wr(`OFS_ACK, 2, `RESP_OKAY);
      rd(`OFS_RAW, 5);
      rd(`OFS_MASKED, 0);
      check({31'h0, IRQ}, 0);
      wr(`OFS_ACK, 5, `RESP_OKAY);
      rd(`OFS_RAW, 0);
      wr(12'h900, 1, `RESP_SLVERR);
   endtask
   task automatic t_enable;
      wr(`OFS_IRQ_EN, 0, `RESP_OKAY);
      rd(`OFS_IRQ_EN, 0);
      @(posedge CLK_SYS);
      start <= 3'h2;
      @(posedge CLK_SYS);
      start <= 3'h0;
      repeat (3) @(posedge CLK_SYS);
      check({31'h0, IRQ}, 0);
      rd(`OFS_MASKED, 2);
      wr(`OFS_IRQ_EN, 1, `RESP_OKAY);
      repeat (2) @(posedge CLK_SYS);
      check({31'h0, IRQ}, 1);
      S_AXI_WSTRB <= 4'h0;
      wr(`OFS_ACK, 2, `RESP_OKAY);
      S_AXI_WSTRB <= 4'hF;
      rd(`OFS_RAW, 2);
      wr(`OFS_ACK, 2, `RESP_OKAY);
      rd(`OFS_RAW, 0);
      check({31'h0, IRQ}, 0);
      rd(12'h900, 0);
      check({30'h0, S_AXI_RRESP}, {30'h0, `RESP_SLVERR});
   endtask
   initial
   begin
      repeat (3) @(posedge CLK_SYS);
      NRST <= 1'b1;
      t_reset;
      t_events;
      t_mask_ack;
      t_enable;
      complete_run;
   end
endmodule // test_hash_dma_event_status
bind dma_event_status dma_event_status_monitor #(.AW(AW)) u_mon (.*);
